/* hw/adcsq_defines.vh */
// Summary of operation
// - in-range input gives code 4096*(input - low reference)/3 V.
// - input at or above 3 V gives 4095, at or below 0 V gives 0.
// - one session runs up to sixteen conversions, each state picks any channel.
// - two independent eight-state sequencers, or one cascaded sixteen-state sequencer.
// - one shared converter, so only one conversion runs at a time.
// - in dual mode each sequencer picks only within its own eight channels.
// - each result lands in its state's result register; sixteen addressable results.
// - the same channel may appear in several states for oversampling.
// - a sequence starts by software, by a pwm trigger, or by external interrupt two.
// - interrupt request at every end of sequence or every second one.
// - start/stop mode: each trigger advances the sequence by one conversion.
// - in dual mode pwm triggers a and b start their own sequencer.
// - acquisition window prescale is separate from the converter clock setting.
// - registers run at system clock; conversion timing runs on the fast peripheral clock.
// - clock enable clears on reset; registers reset; analog part stays powered down.
// - registers frozen until software sets clock enable, which also powers the analog part.
// - halt powers down the analog part, stops the sequencer, blocks all writes but clock control and keeps all register contents.
// - conversion takes as little as 80 ns with a 25 MHz converter clock.
// - reference select bits 15:14 choose internal or external reference input.
// - control one bit 14 resets the module, trim values then need reloading.
// - results readable left justified and right justified at two addresses.
`ifndef ADCSQ_DEFINES_VH
`define ADCSQ_DEFINES_VH
// register word offsets
`define A_CTRL1 6'h00
`define A_CTRL2 6'h01
`define A_MAXCONV 6'h02
`define A_CHSEL0 6'h03
`define A_SEQSTAT 6'h07
`define A_RESULT_L 6'h08
`define A_CTRL3 6'h18
`define A_STATUS 6'h19
`define A_REFSEL 6'h1c
`define A_OFFTRIM 6'h1d
`define A_RESULT_R 6'h20
`define A_CLKCTRL 6'h30
// control one fields
`define C1_SOFT_RESET 14
`define C1_START_STOP 6
`define C1_CASCADE 4
`define C1_ACQ_LSB 8
// control two fields
`define C2_SW_START0 13
`define C2_EVERY_OTHER0 11
`define C2_INT_EN0 10
`define C2_EXT_EN0 9
`define C2_PWM_EN0 8
`define C2_SW_START1 5
`define C2_EVERY_OTHER1 3
`define C2_INT_EN1 2
`define C2_PWM_EN1 0
`define C2_STORE_MASK 16'hdfdf
// reset values
`define RST_CTRL3 16'h0007
`define RST_ZERO 16'h0000
// timing
`define REF_CLK_MHZ 200
`define CONV_TIME_NS 80
`define CONV_CLK_MHZ 25
`define CONV_CLKS ((`CONV_TIME_NS * `CONV_CLK_MHZ + 999) / 1000)
// input scale in millivolts
`define FULL_SCALE_MV 3000
`endif

/* hw/adcsq_top.v */
// The implementer's own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "adcsq_defines.vh"
module adcsq_top (
   // clock and reset
   input wire i_ref_clk,
   input wire i_rst_n,
   // register port
   input wire [5:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   output reg [15:0] o_rdata,
   // trigger and mode pins
   input wire i_pwm_trigger_a,
   input wire i_pwm_trigger_b,
   input wire i_external_interrupt_two,
   input wire i_halt,
   // analog core side
   input wire signed [13:0] i_input_mv,
   input wire signed [13:0] i_low_reference_input_mv,
   output reg [3:0] o_mux_channel,
   output reg o_acquire,
   output reg o_converting,
   output reg o_analog_power_down,
   output reg [1:0] o_ref_select,
   output reg [15:0] o_offset_trim,
   // interrupt requests
   output reg o_irq_seq0,
   output reg o_irq_seq1
);

   localparam ST_IDLE = 3'b001;
   localparam ST_ACQ = 3'b010;
   localparam ST_CONV = 3'b100;
   localparam integer CONV_LAST_I = `CONV_CLKS - 1;
   localparam integer FULL_I = `FULL_SCALE_MV;
   localparam [3:0] CONV_LAST = CONV_LAST_I[3:0];
   localparam signed [13:0] FULL_MV = FULL_I[13:0];
   localparam signed [27:0] SPAN_MV = FULL_I[27:0];

   // millivolts to saturated 12-bit code
   function [11:0] mv_to_code;
      input signed [13:0] vin;
      input signed [13:0] lo;
      reg signed [15:0] diff;
      reg signed [27:0] quo;
      begin
         diff = vin - lo;
         quo = $signed({diff, 12'h000}) / SPAN_MV;
         if (vin <= 14'sd0) begin
            mv_to_code = 12'h000;
         end else if (vin >= FULL_MV) begin
            mv_to_code = 12'hfff;
         end else if (quo < 28'sd0) begin
            mv_to_code = 12'h000;
         end else if (quo > 28'sd4095) begin
            mv_to_code = 12'hfff;
         end else begin
            mv_to_code = quo[11:0];
         end
      end
   endfunction

   reg clk_en, sreset, fast_tick;
   reg [2:0] fast_div, fast_cnt;
   reg [15:0] ctrl1, ctrl2, ctrl3, maxconv, refsel, next_rdata;
   reg [15:0] chsel [0:3];
   reg [11:0] result [0:15];
   reg [3:0] conv_cnt, ptr0, ptr1, phase;
   reg go0, go1, par0, par1, flag0, flag1, sel;
   reg [2:0] state;
   reg [2:0] meta_trig, sync_trig, prev_trig;
   reg meta_halt, halt_s;
   reg [13:0] meta_vin, vin_s, meta_lo, lo_s;
   integer k;

   wire run = clk_en & ~halt_s;
   wire wr_mod = i_wr & run;
   wire [2:0] rise = sync_trig & ~prev_trig;
   wire cascade = ctrl1[`C1_CASCADE];
   wire conv_tick = fast_tick & (conv_cnt == ctrl3[3:0]);
   wire [3:0] acq_len = ctrl1[`C1_ACQ_LSB+3:`C1_ACQ_LSB];
   wire [3:0] last0 = cascade ? maxconv[3:0] : {1'b0, maxconv[2:0]};
   wire [3:0] last1 = {1'b1, maxconv[6:4]};
   wire [3:0] cur_idx = sel ? ptr1 : ptr0;
   wire [3:0] cur_last = sel ? last1 : last0;
   wire [3:0] sel_nib0 = chsel[ptr0[3:2]][{ptr0[1:0], 2'b00} +: 4];
   wire [3:0] sel_nib1 = chsel[ptr1[3:2]][{ptr1[1:0], 2'b00} +: 4];
   wire [11:0] code = mv_to_code(vin_s, lo_s);

   // software and pin start requests
   wire wr_c2 = wr_mod & (i_addr == `A_CTRL2);
   wire start0 = (wr_c2 & i_wdata[`C2_SW_START0])
      | (rise[0] & ctrl2[`C2_PWM_EN0])
      | (rise[2] & ctrl2[`C2_EXT_EN0]);
   wire start1 = ~cascade & ((wr_c2 & i_wdata[`C2_SW_START1])
      | (rise[1] & ctrl2[`C2_PWM_EN1]));
   wire done = (state == ST_CONV) & conv_tick & (phase == CONV_LAST);
   wire end_of_sequence = done & (cur_idx == cur_last);
   wire eos0 = end_of_sequence & ~sel;
   wire eos1 = end_of_sequence & sel;
   wire irq0 = eos0 & ctrl2[`C2_INT_EN0] & (~ctrl2[`C2_EVERY_OTHER0] | par0);
   wire irq1 = eos1 & ctrl2[`C2_INT_EN1] & (~ctrl2[`C2_EVERY_OTHER1] | par1);
   wire stop_step = done & ctrl1[`C1_START_STOP];
   wire wr_stat = wr_mod & (i_addr == `A_STATUS);

   // two-flop synchronisers for pins
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         meta_trig <= 3'h0;
         sync_trig <= 3'h0;
         prev_trig <= 3'h0;
         meta_halt <= 1'b0;
         halt_s <= 1'b0;
         meta_vin <= 14'h0000;
         vin_s <= 14'h0000;
         meta_lo <= 14'h0000;
         lo_s <= 14'h0000;
      end else begin
         meta_trig <= {i_external_interrupt_two, i_pwm_trigger_b, i_pwm_trigger_a};
         sync_trig <= meta_trig;
         prev_trig <= sync_trig;
         meta_halt <= i_halt;
         halt_s <= meta_halt;
         meta_vin <= i_input_mv;
         vin_s <= meta_vin;
         meta_lo <= i_low_reference_input_mv;
         lo_s <= meta_lo;
      end
   end

   // clock control register, outside the module reset
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         clk_en <= 1'b0;
         fast_div <= 3'h0;
         o_analog_power_down <= 1'b1;
      end else begin
         if (i_wr && (i_addr == `A_CLKCTRL)) begin
            clk_en <= i_wdata[0];
            fast_div <= i_wdata[3:1];
         end
         o_analog_power_down <= ~clk_en | halt_s;
      end
   end

   // fast peripheral clock and converter clock enables
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         fast_cnt <= 3'h0;
         fast_tick <= 1'b0;
         conv_cnt <= 4'h0;
      end else if (!run || sreset) begin
         fast_cnt <= 3'h0;
         fast_tick <= 1'b0;
         conv_cnt <= 4'h0;
      end else begin
         fast_tick <= (fast_cnt == fast_div);
         fast_cnt <= (fast_cnt == fast_div) ? 3'h0 : fast_cnt + 3'h1;
         if (fast_tick) begin
            conv_cnt <= conv_tick ? 4'h0 : conv_cnt + 4'h1;
         end
      end
   end

   // registers and sequencer, register clock gated by run
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         ctrl1 <= `RST_ZERO;
         ctrl2 <= `RST_ZERO;
         ctrl3 <= `RST_CTRL3;
         maxconv <= `RST_ZERO;
         refsel <= `RST_ZERO;
         o_offset_trim <= `RST_ZERO;
         o_ref_select <= 2'b00;
         for (k = 0; k < 4; k = k + 1) begin
            chsel[k] <= `RST_ZERO;
         end
         for (k = 0; k < 16; k = k + 1) begin
            result[k] <= 12'h000;
         end
         sreset <= 1'b0;
         ptr0 <= 4'h0;
         ptr1 <= 4'h8;
         go0 <= 1'b0;
         go1 <= 1'b0;
         par0 <= 1'b0;
         par1 <= 1'b0;
         flag0 <= 1'b0;
         flag1 <= 1'b0;
         sel <= 1'b0;
         state <= ST_IDLE;
         phase <= 4'h0;
         o_mux_channel <= 4'h0;
         o_acquire <= 1'b0;
         o_converting <= 1'b0;
         o_irq_seq0 <= 1'b0;
         o_irq_seq1 <= 1'b0;
      end else if (sreset) begin
         ctrl1 <= `RST_ZERO;
         ctrl2 <= `RST_ZERO;
         ctrl3 <= `RST_CTRL3;
         maxconv <= `RST_ZERO;
         refsel <= `RST_ZERO;
         o_offset_trim <= `RST_ZERO;
         o_ref_select <= 2'b00;
         for (k = 0; k < 4; k = k + 1) begin
            chsel[k] <= `RST_ZERO;
         end
         for (k = 0; k < 16; k = k + 1) begin
            result[k] <= 12'h000;
         end
         sreset <= 1'b0;
         ptr0 <= 4'h0;
         ptr1 <= 4'h8;
         go0 <= 1'b0;
         go1 <= 1'b0;
         par0 <= 1'b0;
         par1 <= 1'b0;
         flag0 <= 1'b0;
         flag1 <= 1'b0;
         sel <= 1'b0;
         state <= ST_IDLE;
         phase <= 4'h0;
         o_acquire <= 1'b0;
         o_converting <= 1'b0;
         o_irq_seq0 <= 1'b0;
         o_irq_seq1 <= 1'b0;
      end else if (run) begin
         // register writes
         if (wr_mod) begin
            case (i_addr)
               `A_CTRL1: begin
                  ctrl1 <= i_wdata & 16'hbfff;
                  sreset <= i_wdata[`C1_SOFT_RESET];
               end
               `A_CTRL2: ctrl2 <= i_wdata & `C2_STORE_MASK;
               `A_MAXCONV: maxconv <= i_wdata & 16'h007f;
               `A_CTRL3: ctrl3 <= i_wdata & 16'h000f;
               `A_REFSEL: begin
                  refsel <= i_wdata & 16'hc000;
                  o_ref_select <= i_wdata[15:14];
               end
               `A_OFFTRIM: o_offset_trim <= i_wdata;
               default: begin
                  if (i_addr >= `A_CHSEL0 && i_addr < `A_SEQSTAT) begin
                     chsel[i_addr[1:0] + 2'b01] <= i_wdata;
                  end
               end
            endcase
         end
         // sticky end-of-sequence flags, set wins over clear
         flag0 <= (flag0 & ~(wr_stat & i_wdata[0])) | irq0;
         flag1 <= (flag1 & ~(wr_stat & i_wdata[1])) | irq1;
         o_irq_seq0 <= irq0;
         o_irq_seq1 <= irq1;
         if (eos0) begin
            par0 <= ~par0;
         end
         if (eos1) begin
            par1 <= ~par1;
         end
         // run flags, a new start wins over a stop in the same cycle
         go0 <= (go0 & ~((eos0 | (stop_step & ~sel)))) | start0;
         go1 <= (go1 & ~((eos1 | (stop_step & sel)))) | start1;
         // single shared converter
         case (state)
            ST_IDLE: begin
               phase <= 4'h0;
               if (go0) begin
                  sel <= 1'b0;
                  o_mux_channel <= cascade ? sel_nib0 : {1'b0, sel_nib0[2:0]};
                  o_acquire <= 1'b1;
                  state <= ST_ACQ;
               end else if (go1 && !cascade) begin
                  sel <= 1'b1;
                  o_mux_channel <= {1'b1, sel_nib1[2:0]};
                  o_acquire <= 1'b1;
                  state <= ST_ACQ;
               end
            end
            ST_ACQ: begin
               if (conv_tick) begin
                  if (phase == acq_len) begin
                     phase <= 4'h0;
                     o_acquire <= 1'b0;
                     o_converting <= 1'b1;
                     state <= ST_CONV;
                  end else begin
                     phase <= phase + 4'h1;
                  end
               end
            end
            ST_CONV: begin
               if (conv_tick) begin
                  if (phase == CONV_LAST) begin
                     result[cur_idx] <= code;
                     o_converting <= 1'b0;
                     state <= ST_IDLE;
                     if (cur_idx == cur_last) begin
                        if (sel) begin
                           ptr1 <= 4'h8;
                        end else begin
                           ptr0 <= 4'h0;
                        end
                     end else if (sel) begin
                        ptr1 <= ptr1 + 4'h1;
                     end else begin
                        ptr0 <= ptr0 + 4'h1;
                     end
                  end else begin
                     phase <= phase + 4'h1;
                  end
               end
            end
            default: begin
               state <= ST_IDLE;
               o_acquire <= 1'b0;
               o_converting <= 1'b0;
            end
         endcase
      end else begin
         o_irq_seq0 <= 1'b0;
         o_irq_seq1 <= 1'b0;
      end
   end

   // read decode
   always @* begin
      next_rdata = 16'h0000;
      if (i_addr >= `A_RESULT_L && i_addr < `A_CTRL3) begin
         next_rdata = {result[i_addr[3:0] - 4'h8], 4'h0};
      end else if (i_addr[5:4] == 2'b10) begin
         next_rdata = {4'h0, result[i_addr[3:0]]};
      end else if (i_addr >= `A_CHSEL0 && i_addr < `A_SEQSTAT) begin
         next_rdata = chsel[i_addr[1:0] + 2'b01];
      end else begin
         case (i_addr)
            `A_CTRL1: next_rdata = ctrl1;
            `A_CTRL2: next_rdata = ctrl2;
            `A_MAXCONV: next_rdata = maxconv;
            `A_SEQSTAT: next_rdata = {8'h00, ptr1, ptr0};
            `A_CTRL3: next_rdata = ctrl3;
            `A_STATUS: next_rdata = {12'h000, go1, go0, flag1, flag0};
            `A_REFSEL: next_rdata = refsel;
            `A_OFFTRIM: next_rdata = o_offset_trim;
            `A_CLKCTRL: next_rdata = {12'h000, fast_div, clk_en};
            default: next_rdata = 16'h0000;
         endcase
      end
   end

   // read data stands for one cycle after the strobe
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= 16'h0000;
      end else if (i_rd) begin
         o_rdata <= next_rdata;
      end else begin
         o_rdata <= 16'h0000;
      end
   end

endmodule

/* verif/adcsq_analog_model.sv */
`timescale 1ns/1ps
module adcsq_analog_model (
   // mux side of the converter
   input wire [3:0] i_mux_channel,
   // level of the selected input in millivolts
   output reg signed [13:0] o_input_mv
);
   integer mv;
   // fixed level per channel, upper group shifted by half a step
   always @* begin
      mv = i_mux_channel[2:0] * 750 - 750 + i_mux_channel[3] * 375;
      o_input_mv = mv[13:0];
   end
endmodule

/* verif/adcsq_checker_assertions.sv */
`timescale 1ns/1ps
`include "adcsq_defines.vh"
module adcsq_checker (
   // clock and reset
   input wire i_ref_clk,
   input wire i_rst_n,
   // register port
   input wire [5:0] i_addr,
   input wire [15:0] i_wdata,
   input wire i_wr,
   input wire i_rd,
   input wire [15:0] o_rdata,
   // trigger and mode pins
   input wire i_pwm_trigger_a,
   input wire i_pwm_trigger_b,
   input wire i_external_interrupt_two,
   input wire i_halt,
   // analog core side
   input wire signed [13:0] i_input_mv,
   input wire signed [13:0] i_low_reference_input_mv,
   input wire [3:0] o_mux_channel,
   input wire o_acquire,
   input wire o_converting,
   input wire o_analog_power_down,
   input wire [1:0] o_ref_select,
   input wire [15:0] o_offset_trim,
   // interrupt requests
   input wire o_irq_seq0,
   input wire o_irq_seq1
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   property p_pd_rst; disable iff (1'b0) !i_rst_n |-> o_analog_power_down; endproperty
   a_pd_rst: assert property (p_pd_rst) else $error("analog part awake in reset");
   property p_rdata_idle; !$past(i_rd) |-> o_rdata == 16'h0000; endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data without read");
   property p_one_conv; !(o_acquire && o_converting); endproperty
   a_one_conv: assert property (p_one_conv) else $error("acquire and convert overlap");
   property p_irq_excl; !(o_irq_seq0 && o_irq_seq1); endproperty
   a_irq_excl: assert property (p_irq_excl) else $error("two ends of sequence at once");
   property p_irq_pulse; o_irq_seq0 |=> !o_irq_seq0; endproperty
   a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt pulse too long");
   property p_halt_pd; i_halt [*4] |-> o_analog_power_down; endproperty
   a_halt_pd: assert property (p_halt_pd) else $error("analog part awake in halt");
   property p_mux_hold; o_converting |-> $stable(o_mux_channel); endproperty
   a_mux_hold: assert property (p_mux_hold) else $error("channel moved while converting");
   property p_acq_first; $rose(o_converting) |-> $past(o_acquire); endproperty
   a_acq_first: assert property (p_acq_first) else $error("conversion without acquire");
   property p_refsel;
      i_wr && i_addr == `A_REFSEL && !o_analog_power_down && !i_halt
      |=> {o_ref_select, 14'h0000} == ($past(i_wdata) & 16'hc000);
   endproperty
   a_refsel: assert property (p_refsel) else $error("reference select not taken");
   property p_soft_rst;
      i_wr && i_addr == `A_CTRL1 && i_wdata[14] && !o_analog_power_down && !i_halt
      |-> ##2 o_ref_select == 2'b00 && o_offset_trim == 16'h0000;
   endproperty
   a_soft_rst: assert property (p_soft_rst) else $error("soft reset kept trim values");
endmodule
bind adcsq_top adcsq_checker CHK (.*);

/* verif/tb.sv */
`timescale 1ns/1ps
`include "adcsq_defines.vh"
module tb;
   reg i_ref_clk = 1'b0;
   reg i_rst_n = 1'b1;
   reg [5:0] i_addr = 6'h00;
   reg [15:0] i_wdata = 16'h0000;
   reg i_wr = 1'b0, i_rd = 1'b0, i_halt = 1'b0;
   reg i_pwm_trigger_a = 1'b0, i_pwm_trigger_b = 1'b0, i_external_interrupt_two = 1'b0;
   reg signed [13:0] i_low_reference_input_mv = 14'sd0;
   wire signed [13:0] i_input_mv;
   wire [15:0] o_rdata, o_offset_trim;
   wire [3:0] o_mux_channel;
   wire [1:0] o_ref_select;
   wire o_acquire, o_converting, o_analog_power_down, o_irq_seq0, o_irq_seq1;
   integer bad_count = 0, n_tests = 0, conv_cnt = 0, irq0 = 0, irq1 = 0;
   reg cv_d = 1'b0;
   reg [15:0] rv;
   reg [5:0] k;

   adcsq_top DUT (.*);
   adcsq_analog_model MODEL (.i_mux_channel(o_mux_channel), .o_input_mv(i_input_mv));

   // clock source
   initial begin
      forever #2.5 i_ref_clk = ~i_ref_clk;
   end

   // count finished conversions and interrupt pulses
   always @(posedge i_ref_clk) begin
      cv_d <= o_converting;
      if (cv_d === 1'b1 && o_converting === 1'b0) conv_cnt <= conv_cnt + 1;
      if (o_irq_seq0 === 1'b1) irq0 <= irq0 + 1;
      if (o_irq_seq1 === 1'b1) irq1 <= irq1 + 1;
   end

   function [11:0] code_of(input integer ch);
      integer mv;
      begin
         mv = (ch % 8) * 750 - 750 + (ch / 8) * 375;
         if (mv <= 0) code_of = 12'h000;
         else if (mv >= 3000) code_of = 12'hfff;
         else code_of = (4096 * mv) / 3000;
      end
   endfunction

   task print_verdict;
      begin
         $display("comparisons %0d mismatches %0d", n_tests, bad_count);
         if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask

   task chk(input [15:0] got, input [15:0] exp);
      begin
         n_tests = n_tests + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask

   task wr(input [5:0] a, input [15:0] d);
      begin
         @(posedge i_ref_clk);
         i_wr <= 1'b1;
         i_addr <= a;
         i_wdata <= d;
         @(posedge i_ref_clk);
         i_wr <= 1'b0;
      end
   endtask

   // read data stand only in the cycle after the strobe
   task rchk(input [5:0] a, input [15:0] exp);
      begin
         @(posedge i_ref_clk);
         i_rd <= 1'b1;
         i_addr <= a;
         @(posedge i_ref_clk);
         i_rd <= 1'b0;
         #1 rv = o_rdata;
         chk(rv, exp);
      end
   endtask

   task trig(input integer s);
      begin
         @(posedge i_ref_clk);
         if (s == 0) i_pwm_trigger_a <= 1'b1;
         else if (s == 1) i_pwm_trigger_b <= 1'b1;
         else i_external_interrupt_two <= 1'b1;
         repeat (4) @(posedge i_ref_clk);
         i_pwm_trigger_a <= 1'b0;
         i_pwm_trigger_b <= 1'b0;
         i_external_interrupt_two <= 1'b0;
      end
   endtask

   task wait_conv(input integer n);
      integer t;
      begin
         for (t = 0; t < 4000 && conv_cnt < n; t = t + 1) @(posedge i_ref_clk);
         if (conv_cnt < n) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED at %0t: conversion never finished", $time);
            print_verdict;
         end else begin
            repeat (4) @(posedge i_ref_clk);
         end
      end
   endtask

   task s_enable;
      begin
         rchk(`A_CTRL3, `RST_CTRL3);
         chk({15'h0000, o_analog_power_down}, 16'h0001);
         wr(`A_REFSEL, 16'hc000);
         rchk(`A_REFSEL, `RST_ZERO);
         wr(`A_CLKCTRL, 16'h0001);
         repeat (20) @(posedge i_ref_clk); // scaled settling wait
         chk({15'h0000, o_analog_power_down}, 16'h0000);
         wr(`A_REFSEL, 16'h4000);
         rchk(`A_REFSEL, 16'h4000);
         chk({14'h0000, o_ref_select}, 16'h0001);
         rchk(6'h1a, 16'h0000);
      end
   endtask

   task s_dual;
      begin
         wr(`A_CHSEL0, 16'h0322);
         wr(`A_MAXCONV, 16'h0002);
         wr(`A_CTRL2, 16'h2400);
         wait_conv(3);
         for (k = 0; k < 3; k = k + 1) begin
            rchk(`A_RESULT_L + k, {code_of(k == 2 ? 3 : 2), 4'h0});
            rchk(`A_RESULT_R + k, {4'h0, code_of(k == 2 ? 3 : 2)});
         end
         rchk(`A_SEQSTAT, 16'h0080);
         chk(irq0[15:0], 16'h0001);
         rchk(`A_STATUS, 16'h0001);
         wr(`A_STATUS, 16'h0001);
         rchk(`A_STATUS, 16'h0000);
      end
   endtask

   task s_seq1;
      begin
         wr(6'h05, 16'h0002);
         wr(`A_CTRL2, 16'h0005);
         trig(1);
         wait_conv(4);
         chk({12'h000, o_mux_channel}, 16'h000a);
         rchk(`A_RESULT_R + 6'h08, {4'h0, code_of(10)});
         rchk(`A_SEQSTAT, 16'h0080);
         chk(irq1[15:0], 16'h0001);
      end
   endtask

   task s_every;
      begin
         wr(`A_OFFTRIM, 16'h1234);
         @(posedge i_ref_clk);
         chk(o_offset_trim, 16'h1234);
         wr(`A_CTRL1, 16'h4000);
         rchk(`A_REFSEL, `RST_ZERO);
         rchk(`A_CTRL3, `RST_CTRL3);
         chk(o_offset_trim, 16'h0000);
         wr(`A_CTRL2, 16'h0e00);
         trig(2);
         wait_conv(5);
         chk(irq0[15:0], 16'h0001);
         trig(2);
         wait_conv(6);
         chk(irq0[15:0], 16'h0002);
      end
   endtask

   task s_startstop;
      begin
         wr(`A_CTRL1, 16'h0040);
         wr(`A_CTRL2, 16'h0500);
         wr(`A_MAXCONV, 16'h0001);
         wr(`A_CHSEL0, 16'h0042);
         trig(0);
         wait_conv(7);
         i_low_reference_input_mv <= 14'sd750; // lower reference for the second step
         rchk(`A_SEQSTAT, 16'h0081);
         chk(irq0[15:0], 16'h0002);
         trig(0);
         wait_conv(8);
         i_low_reference_input_mv <= 14'sd0;
         rchk(`A_SEQSTAT, 16'h0080);
         rchk(`A_RESULT_R + 6'h01, 16'h0800);
         rchk(`A_RESULT_R, {4'h0, code_of(2)});
         chk(irq0[15:0], 16'h0003);
      end
   endtask

   task s_cascade;
      begin
         wr(`A_CTRL1, 16'h0110);
         wr(`A_MAXCONV, 16'h0009);
         wr(6'h05, 16'h00d0);
         wr(`A_CTRL2, 16'h2400);
         trig(1);
         wait_conv(18);
         rchk(6'h05, 16'h00d0);
         rchk(`A_RESULT_R + 6'h09, {4'h0, code_of(13)});
         rchk(`A_RESULT_R + 6'h08, {4'h0, code_of(0)});
         chk(irq0[15:0], 16'h0004);
      end
   endtask

   task s_halt;
      begin
         wr(`A_REFSEL, 16'h4000);
         @(posedge i_ref_clk);
         i_halt <= 1'b1;
         repeat (5) @(posedge i_ref_clk);
         chk({15'h0000, o_analog_power_down}, 16'h0001);
         wr(`A_REFSEL, 16'h8000);
         i_halt <= 1'b0;
         repeat (5) @(posedge i_ref_clk);
         rchk(`A_REFSEL, 16'h4000);
         chk({15'h0000, o_analog_power_down}, 16'h0000);
         wr(`A_CLKCTRL, 16'h0000); // converter no longer used
         repeat (2) @(posedge i_ref_clk);
         chk({15'h0000, o_analog_power_down}, 16'h0001);
      end
   endtask

   // main sequence
   initial begin
      i_rst_n <= 1'b0;
      repeat (10) @(posedge i_ref_clk);
      i_rst_n <= 1'b1;
      s_enable;
      s_dual;
      s_seq1;
      s_every;
      s_startstop;
      s_cascade;
      s_halt;
      print_verdict;
   end
endmodule
